// *** logic/sbt_pkg.sv ***
/*
  package for the standby power-down timer: opcodes, timeout code table,
  time units, status and error bit layouts, and the carrier structs.
  assumes a single 40 MHz core clock.
*/
`default_nettype none
package sbt_pkg;
  // core clock rate
  localparam longint unsigned CLK_HZ = 64'd40_000_000;
  // command opcodes that start the standby command
  localparam logic [7:0] OPC_STANDBY = 8'hE2;
  localparam logic [7:0] OPC_STANDBY_ALT = 8'h96;
  // timeout code boundaries
  localparam logic [7:0] CODE_OFF = 8'h00;
  localparam logic [7:0] CODE_SEC_MAX = 8'hF0;
  localparam logic [7:0] CODE_HALF_HOUR_MAX = 8'hFB;
  localparam logic [7:0] CODE_21MIN = 8'hFC;
  localparam logic [7:0] CODE_8HOUR = 8'hFD;
  localparam logic [7:0] CODE_ABORT = 8'hFE;
  localparam logic [7:0] CODE_21MIN15 = 8'hFF;
  // time units in seconds
  localparam int unsigned UNIT_SEC_S = 5;
  localparam int unsigned UNIT_HALF_HOUR_S = 1800;
  localparam int unsigned T_21MIN_S = 1260;
  localparam int unsigned T_8HOUR_S = 28800;
  localparam int unsigned T_21MIN15_S = 1275;
  // default clocks per second of interval, shortened in simulation
  localparam int unsigned TICKS_PER_SEC = 32'(CLK_HZ);
  // spin-up and spin-down times, both long counts
  localparam int unsigned SPINUP_MS = 8000;
  localparam int unsigned SPINDOWN_MS = 1000;
  localparam int unsigned SPINUP_CYC = 32'((CLK_HZ * SPINUP_MS) / 64'd1000);
  localparam int unsigned SPINDOWN_CYC = 32'((CLK_HZ * SPINDOWN_MS) / 64'd1000);
  // status bit positions
  localparam int unsigned ST_BSY = 7;
  localparam int unsigned ST_RDY = 6;
  localparam int unsigned ST_DF = 5;
  localparam int unsigned ST_DSC = 4;
  localparam int unsigned ST_COR = 2;
  localparam int unsigned ST_ERR = 0;
  // error bit position
  localparam int unsigned ER_ABT = 2;
  localparam logic [7:0] BYTE_ZERO = 8'h00;

  // power states of the drive
  typedef enum logic [2:0] {
    SBT_IDLE = 3'b000,
    SBT_SPIN_DOWN = 3'b001,
    SBT_STANDBY = 3'b010,
    SBT_SPIN_UP = 3'b011,
    SBT_DONE = 3'b100
  } sbt_state_t;

  // command strobe from the task-file decoder
  typedef struct packed {
    logic valid;
    logic [7:0] opcode;
    logic [7:0] count;
  } sbt_cmd_t;

  // completion answer to the task file
  typedef struct packed {
    logic done;
    logic [7:0] status;
    logic [7:0] error;
  } sbt_resp_t;
endpackage
`default_nettype wire

// *** logic/sbt_countdown.sv ***
/*
  loadable down counter with a prescaler: counts whole seconds of clock
  ticks, then seconds down to zero and raises a one-cycle expiry pulse.
  assumes load and enable come from logic on the same clock.
*/
`timescale 1ns/100ps
`default_nettype none
module sbt_countdown #(
  parameter int unsigned TICKS = 40_000_000
) (
  input wire logic mclk,
  input wire logic reset,
  input wire logic ce,
  input wire logic load,
  input wire logic [14:0] load_sec,
  input wire logic run,
  output logic expired
);
  // counter state kept as one struct
  typedef struct packed {
    logic [31:0] tick;
    logic [14:0] sec;
    logic fire;
  } sbt_cnt_t;
  sbt_cnt_t cur;
  sbt_cnt_t next_cur;

  // next-state: load wins over counting so a reload never misses
  always_comb begin
    next_cur = cur;
    next_cur.fire = 1'b0;
    if (load) begin
      next_cur.sec = load_sec;
      next_cur.tick = 32'(TICKS - 1);
    end else if (run && cur.sec != 15'h0000) begin
      if (cur.tick == 32'h0000_0000) begin
        next_cur.tick = 32'(TICKS - 1);
        next_cur.sec = cur.sec - 15'h0001;
        // last second just ran out
        next_cur.fire = (cur.sec == 15'h0001);
      end else begin
        next_cur.tick = cur.tick - 32'h0000_0001;
      end
    end
  end

  // register with clock enable
  always_ff @(posedge mclk) begin
    if (reset) begin
      cur <= '0;
    end else if (ce) begin
      cur <= next_cur;
    end
  end

  assign expired = cur.fire;
endmodule
`default_nettype wire

// *** logic/sbt_standby_timer.sv ***
/*
  standby command handling and automatic power-down timer of a disk drive.
  takes decoded task-file commands and host access pulses, drives spindle
  requests and answers each standby command with status and error bytes.
  assumes cmd and host_access are synchronous to mclk; spindle_stopped and
  spindle_at_speed are pins and are synchronised here.
*/
`timescale 1ns/100ps
`default_nettype none
// Summary of operation
// - standby opcode enters standby, loads interval
// - standby: spindle off, interface still accepts
// - already stopped spindle skips spin-down
// - command in standby waits for spin-up
// - countdown starts only back in idle
// - extended option puts command standby in deepest level
// - code zero disables automatic power-down
// - other non-zero codes except 254 enable power-down
// - codes 1-240 x5s, 241-251 x30min
// - 252 21min, 253 8h, 255 21m15s
// - expiry enters standby by itself
// - host access in idle reloads full interval
module sbt_standby_timer #(
  parameter int unsigned TICKS_PER_SEC = sbt_pkg::TICKS_PER_SEC,
  parameter int unsigned SPINUP_CYC = sbt_pkg::SPINUP_CYC,
  parameter int unsigned SPINDOWN_CYC = sbt_pkg::SPINDOWN_CYC
) (
  input wire logic mclk,
  input wire logic reset,
  input wire logic ce,
  input wire sbt_pkg::sbt_cmd_t cmd,
  input wire logic host_access,
  input wire logic epc_enable,
  input wire logic spindle_stopped,
  input wire logic spindle_at_speed,
  output logic spin_down_req,
  output logic spin_up_req,
  output logic in_standby,
  output logic standby_z,
  output logic cmd_hold,
  output logic timer_enabled,
  output sbt_pkg::sbt_resp_t resp
);
  // all module state in one struct
  typedef struct packed {
    sbt_pkg::sbt_state_t st;
    logic [1:0] stop_sync;
    logic [1:0] speed_sync;
    logic [31:0] wait_cnt;
    logic [14:0] interval;
    logic enabled;
    logic armed;
    logic deep;
    logic by_cmd; // sequence started by a host command, so it must be answered
    logic pend_cmd;
    logic [7:0] pend_opc;
    logic [7:0] pend_cnt;
    logic down_req;
    logic up_req;
    sbt_pkg::sbt_resp_t resp;
  } sbt_regs_t;
  sbt_regs_t r;
  sbt_regs_t next_r;

  // interval decode of the timeout code
  logic [14:0] dec_sec; // interval in seconds
  logic dec_enable; // code turns the timer on
  logic dec_abort; // code is the abort code
  logic load_timer; // restart countdown
  logic expired; // countdown ran out
  logic is_standby_cmd; // command strobe carries the standby opcode

  // table decode, purely combinational
  always_comb begin
    dec_sec = 15'h0000;
    dec_enable = 1'b1;
    dec_abort = 1'b0;
    if (cmd.count == sbt_pkg::CODE_OFF) begin
      dec_enable = 1'b0;
    end else if (cmd.count <= sbt_pkg::CODE_SEC_MAX) begin
      dec_sec = 15'(cmd.count * sbt_pkg::UNIT_SEC_S);
    end else if (cmd.count <= sbt_pkg::CODE_HALF_HOUR_MAX) begin
      dec_sec = 15'((cmd.count - sbt_pkg::CODE_SEC_MAX) * sbt_pkg::UNIT_HALF_HOUR_S);
    end else begin
      case (cmd.count)
        sbt_pkg::CODE_21MIN: dec_sec = 15'(sbt_pkg::T_21MIN_S);
        sbt_pkg::CODE_8HOUR: dec_sec = 15'(sbt_pkg::T_8HOUR_S);
        sbt_pkg::CODE_21MIN15: dec_sec = 15'(sbt_pkg::T_21MIN15_S);
        default: begin
          // abort code keeps the old setting
          dec_abort = 1'b1;
          dec_enable = 1'b0;
        end
      endcase
    end
  end

  assign is_standby_cmd = cmd.valid &&
    (cmd.opcode == sbt_pkg::OPC_STANDBY || cmd.opcode == sbt_pkg::OPC_STANDBY_ALT);

  // reload on a new setting, on a host access in idle, and when idle is reached
  assign load_timer = (r.st == sbt_pkg::SBT_IDLE) && (host_access || !r.armed);

  sbt_countdown #(
    .TICKS(TICKS_PER_SEC)
  ) u_count (
    .mclk(mclk),
    .reset(reset),
    .ce(ce),
    .load(load_timer),
    .load_sec(r.interval),
    .run(r.armed && r.enabled && r.st == sbt_pkg::SBT_IDLE),
    .expired(expired)
  );

  // next-state logic of the power state machine
  always_comb begin
    next_r = r;
    next_r.stop_sync = {r.stop_sync[0], spindle_stopped};
    next_r.speed_sync = {r.speed_sync[0], spindle_at_speed};
    next_r.resp.done = 1'b0;
    if (r.wait_cnt != 32'h0000_0000) begin
      next_r.wait_cnt = r.wait_cnt - 32'h0000_0001;
    end
    // arming follows idle: a fresh load happens the first idle cycle
    if (r.st == sbt_pkg::SBT_IDLE) begin
      next_r.armed = 1'b1;
    end else begin
      next_r.armed = 1'b0;
    end
    if (is_standby_cmd && dec_abort) begin
      // abort answers at once and changes nothing else
      next_r.resp.done = 1'b1;
      next_r.resp.status = sbt_pkg::BYTE_ZERO;
      next_r.resp.status[sbt_pkg::ST_ERR] = 1'b1;
      next_r.resp.status[sbt_pkg::ST_RDY] = 1'b1;
      next_r.resp.status[sbt_pkg::ST_DSC] = 1'b1;
      next_r.resp.error = sbt_pkg::BYTE_ZERO;
      next_r.resp.error[sbt_pkg::ER_ABT] = 1'b1;
    end else if (is_standby_cmd) begin
      next_r.enabled = dec_enable;
      next_r.interval = dec_sec;
      next_r.deep = epc_enable;
      next_r.armed = 1'b0;
      next_r.pend_cmd = 1'b0;
      next_r.by_cmd = 1'b1;
      // drop the spin-up request on every path: otherwise a command during
      // spin-up would take the skip path and sit in standby still asking for speed
      next_r.up_req = 1'b0;
      if (r.stop_sync[1]) begin
        next_r.st = sbt_pkg::SBT_DONE;
      end else begin
        next_r.st = sbt_pkg::SBT_SPIN_DOWN;
        next_r.down_req = 1'b1;
        next_r.up_req = 1'b0;
        next_r.wait_cnt = 32'(SPINDOWN_CYC);
      end
    end else begin
      case (r.st)
        sbt_pkg::SBT_IDLE: begin
          if (expired) begin
            // timer expiry spins down on its own
            next_r.deep = 1'b0;
            // nobody asked for this standby, so nobody gets an answer
            next_r.by_cmd = 1'b0;
            next_r.down_req = 1'b1;
            next_r.st = r.stop_sync[1] ? sbt_pkg::SBT_STANDBY : sbt_pkg::SBT_SPIN_DOWN;
            next_r.wait_cnt = 32'(SPINDOWN_CYC);
          end
        end
        sbt_pkg::SBT_SPIN_DOWN: begin
          // done once the spindle reports stopped or the time ran out
          if (r.stop_sync[1] || r.wait_cnt == 32'h0000_0000) begin
            // only a command-started sequence passes through the answer state
            if (r.by_cmd) begin
              next_r.st = sbt_pkg::SBT_DONE;
            end else begin
              next_r.st = sbt_pkg::SBT_STANDBY;
            end
          end
        end
        sbt_pkg::SBT_DONE: begin
          // command completion: no error, ready
          next_r.resp.done = 1'b1;
          next_r.resp.status = sbt_pkg::BYTE_ZERO;
          next_r.resp.status[sbt_pkg::ST_RDY] = 1'b1;
          next_r.resp.status[sbt_pkg::ST_DSC] = 1'b1;
          next_r.resp.error = sbt_pkg::BYTE_ZERO;
          next_r.st = sbt_pkg::SBT_STANDBY;
        end
        sbt_pkg::SBT_STANDBY: begin
          // interface stays live; a command wakes the spindle
          next_r.down_req = 1'b1;
          if (cmd.valid) begin
            next_r.pend_cmd = 1'b1;
            next_r.pend_opc = cmd.opcode;
            next_r.pend_cnt = cmd.count;
            next_r.down_req = 1'b0;
            next_r.up_req = 1'b1;
            next_r.wait_cnt = 32'(SPINUP_CYC);
            next_r.st = sbt_pkg::SBT_SPIN_UP;
          end
        end
        sbt_pkg::SBT_SPIN_UP: begin
          // release the held command at operating speed or when the spin-up time runs out
          if (r.speed_sync[1] || r.wait_cnt == 32'h0000_0000) begin
            next_r.up_req = 1'b0;
            next_r.pend_cmd = 1'b0;
            next_r.deep = 1'b0;
            next_r.st = sbt_pkg::SBT_IDLE;
          end
        end
        default: begin
          next_r.st = sbt_pkg::SBT_IDLE;
        end
      endcase
    end
  end

  // state register with clock enable and synchronous reset
  always_ff @(posedge mclk) begin
    if (reset) begin
      r <= '0;
    end else if (ce) begin
      r <= next_r;
    end
  end

  // outputs
  assign spin_down_req = r.down_req;
  assign spin_up_req = r.up_req;
  assign in_standby = (r.st == sbt_pkg::SBT_STANDBY) || (r.st == sbt_pkg::SBT_SPIN_UP);
  assign standby_z = in_standby && r.deep;
  assign cmd_hold = r.pend_cmd;
  assign timer_enabled = r.enabled;
  assign resp = r.resp;

  // a standby command while idle leaves idle next cycle
  a_cmd_leaves_idle: assert property (@(posedge mclk) disable iff (reset)
    ce && is_standby_cmd && !dec_abort && r.st == sbt_pkg::SBT_IDLE |=> r.st != sbt_pkg::SBT_IDLE)
    else $error("standby command did not leave idle");
  // spindle is not asked to spin while in standby
  a_standby_spindle_off: assert property (@(posedge mclk) disable iff (reset)
    r.st == sbt_pkg::SBT_STANDBY |-> !r.up_req)
    else $error("spin-up requested during standby");
  // stopped spindle goes straight to completion
  a_skip_spin_down: assert property (@(posedge mclk) disable iff (reset)
    ce && is_standby_cmd && !dec_abort && r.stop_sync[1] |=> r.st == sbt_pkg::SBT_DONE)
    else $error("spin-down not skipped");
  // held command is released only after spin-up
  a_hold_until_speed: assert property (@(posedge mclk) disable iff (reset)
    $fell(r.pend_cmd) && !$past(is_standby_cmd) |-> $past(r.st) == sbt_pkg::SBT_SPIN_UP)
    else $error("command released before spin-up");
  // countdown never expires outside idle; a standby command landing on the
  // last tick leaves idle together with the pulse, which is then dropped
  a_expire_idle_only: assert property (@(posedge mclk) disable iff (reset)
    ce && expired && !$past(is_standby_cmd) |-> r.st == sbt_pkg::SBT_IDLE)
    else $error("timer expired outside idle");
  // deep standby follows the option bit
  a_deep_standby: assert property (@(posedge mclk) disable iff (reset)
    ce && is_standby_cmd && !dec_abort && epc_enable |=> r.deep)
    else $error("deep standby not taken");
  // zero code turns the timer off
  a_zero_disables: assert property (@(posedge mclk) disable iff (reset)
    ce && is_standby_cmd && cmd.count == sbt_pkg::CODE_OFF |=> !r.enabled)
    else $error("zero code left timer on");
  // normal code turns the timer on
  a_code_enables: assert property (@(posedge mclk) disable iff (reset)
    ce && is_standby_cmd && cmd.count != sbt_pkg::CODE_OFF && cmd.count != sbt_pkg::CODE_ABORT |=> r.enabled)
    else $error("code did not enable timer");
  // five-second step decode
  a_decode_seconds: assert property (@(posedge mclk) disable iff (reset)
    ce && is_standby_cmd && cmd.count == 8'h01 |=> r.interval == 15'h0005)
    else $error("code 1 decode wrong");
  // eight-hour code decode
  a_decode_special: assert property (@(posedge mclk) disable iff (reset)
    ce && is_standby_cmd && cmd.count == sbt_pkg::CODE_8HOUR |=> r.interval == 15'h7080)
    else $error("code 253 decode wrong");
  // expiry starts spin-down next cycle
  a_expiry_standby: assert property (@(posedge mclk) disable iff (reset)
    ce && expired && !cmd.valid |=> r.down_req && r.st != sbt_pkg::SBT_IDLE)
    else $error("expiry ignored");
  // abort answers with the documented bytes
  a_abort_answer: assert property (@(posedge mclk) disable iff (reset)
    ce && is_standby_cmd && cmd.count == sbt_pkg::CODE_ABORT
    |=> resp.done && resp.error == 8'h04 && resp.status == 8'h51)
    else $error("abort answer wrong");
  // host access holds off expiry the cycle after
  a_access_reload: assert property (@(posedge mclk) disable iff (reset)
    ce && host_access && r.st == sbt_pkg::SBT_IDLE |=> !expired)
    else $error("expiry right after host access");
  // timer-started spin-down never produces a completion
  a_timer_no_answer: assert property (@(posedge mclk) disable iff (reset)
    ce && r.st == sbt_pkg::SBT_SPIN_DOWN && !r.by_cmd && !is_standby_cmd |=> !resp.done)
    else $error("answer given for timer standby");
  // a held command stays held while the spindle is below speed and spin-up time remains
  a_hold_below_speed: assert property (@(posedge mclk) disable iff (reset)
    ce && r.st == sbt_pkg::SBT_SPIN_UP && !is_standby_cmd && !r.speed_sync[1] && r.wait_cnt != 32'h0000_0000
    |=> r.st == sbt_pkg::SBT_SPIN_UP && cmd_hold)
    else $error("command released below speed");
endmodule
`default_nettype wire

// *** testbench/sbt_spindle_model.sv ***
/*
  spindle motor model for the standby timer bench.
  assumes the spin requests are registered levels on mclk; a spin phase
  takes lag plus one cycles.
*/
`timescale 1ns/100ps
`default_nettype none
module sbt_spindle_model (
  input wire logic mclk,
  input wire logic spin_down_req,
  input wire logic spin_up_req,
  input wire logic [7:0] lag,
  output logic stopped,
  output logic at_speed
);
  int cnt = 0; // cycles into the current spin phase
  // power-on: spindle at operating speed; one process drives each level
  logic stop_q = 1'b0;
  logic speed_q = 1'b1;
  assign stopped = stop_q;
  assign at_speed = speed_q;
  // speed is lost at once, but the stop and the return to speed take lag plus one cycles
  always @(posedge mclk) begin
    if (spin_down_req && !stop_q) begin
      speed_q <= 1'b0;
      cnt <= cnt + 1;
      if (cnt >= lag) begin
        stop_q <= 1'b1;
        cnt <= 0;
      end
    end else if (spin_up_req && !speed_q) begin
      stop_q <= 1'b0;
      cnt <= cnt + 1;
      if (cnt >= lag) begin
        speed_q <= 1'b1;
        cnt <= 0;
      end
    end else begin
      cnt <= 0;
    end
  end
endmodule
`default_nettype wire

// *** testbench/tb_standby_power_down_timer.sv ***
/*
  self-checking bench for the standby power-down timer.
  assumes short simulation counts: 10 ticks a second, 20-cycle spin-up and spin-down times.
*/
`timescale 1ns/100ps
`default_nettype none
module tb_standby_power_down_timer;
  localparam int TPS = 10; // clocks per second of interval
  logic mclk = 1'b0;
  logic reset = 1'b1;
  logic ce = 1'b1; // clock enable, dropped once to prove the freeze
  sbt_pkg::sbt_cmd_t cmd = '0;
  logic host_access = 1'b0;
  logic epc_enable = 1'b0;
  logic [7:0] lag = 8'h04; // spindle phase length minus one
  logic stopped, at_speed, spin_down_req, spin_up_req, in_standby, standby_z, cmd_hold, timer_enabled;
  sbt_pkg::sbt_resp_t resp;
  int miscompares = 0;
  int num_checks = 0;
  int dones = 0; // answers seen, to prove timer standby gives none
  int n; // cycles counted by the last wait
  logic [7:0] codes [6] = '{8'h00, 8'hF0, 8'hF1, 8'hFC, 8'hFD, 8'hFF};

  always #12.5 mclk = ~mclk;
  always @(posedge mclk) if (resp.done === 1'b1) dones <= dones + 1;

  sbt_standby_timer #(.TICKS_PER_SEC(TPS), .SPINUP_CYC(20), .SPINDOWN_CYC(20)) uut (
    .mclk(mclk), .reset(reset), .ce(ce), .cmd(cmd), .host_access(host_access),
    .epc_enable(epc_enable), .spindle_stopped(stopped), .spindle_at_speed(at_speed),
    .spin_down_req(spin_down_req), .spin_up_req(spin_up_req), .in_standby(in_standby),
    .standby_z(standby_z), .cmd_hold(cmd_hold), .timer_enabled(timer_enabled), .resp(resp));

  sbt_spindle_model spindle (
    .mclk(mclk), .spin_down_req(spin_down_req), .spin_up_req(spin_up_req), .lag(lag),
    .stopped(stopped), .at_speed(at_speed));

  task automatic check(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic report_and_stop();
    if (miscompares == 0 && num_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  // one-cycle command strobe, driven off the sampling edge
  task automatic send(input logic [7:0] opc, input logic [7:0] cnt);
    @(negedge mclk);
    cmd <= '{1'b1, opc, cnt};
    @(negedge mclk);
    cmd.valid <= 1'b0;
  endtask

  // bounded wait: 0 answer, 1 hold released, 2 spin-down raised
  task automatic wait_for(input int sel, input int lim);
    n = 0;
    while (!((sel == 0 && resp.done === 1'b1) || (sel == 1 && cmd_hold === 1'b0) ||
             (sel == 2 && spin_down_req === 1'b1))) begin
      @(negedge mclk);
      n++;
      if (n > lim) begin
        miscompares++;
        report_and_stop();
      end
    end
  endtask

  // interval in cycles that a timeout code selects
  function automatic int exp_cycles(input logic [7:0] c);
    int s;
    if (c >= 8'hF1 && c <= 8'hFB) s = (int'(c) - 240) * 1800;
    else if (c == 8'hFC) s = 1260;
    else if (c == 8'hFD) s = 28800;
    else if (c == 8'hFF) s = 1275;
    else s = int'(c) * 5;
    return s * TPS;
  endfunction

  // wake from standby with a non-standby command; it is held until spin-up
  task automatic wake();
    send(8'h00, 8'h00);
    check("hold", cmd_hold, 1'b1);
    check("spin up", {spin_up_req, spin_down_req}, 2'b10);
    wait_for(1, 200);
    check("late release", n >= lag, 1'b1);
    check("left standby", in_standby, 1'b0);
  endtask

  // program a code, return to idle and time the automatic standby for intervals under 20000 cycles
  task automatic timed(input logic [7:0] code);
    int e;
    int d;
    e = exp_cycles(code);
    send(8'hE2, code);
    wait_for(0, 100);
    check("status", {resp.status, resp.error}, 16'h5000);
    check("enabled", timer_enabled, code != 8'h00);
    wake();
    d = dones;
    if (code == 8'h00) begin
      repeat (300) @(negedge mclk);
      check("no expiry", spin_down_req, 1'b0);
    end else if (e < 20000) begin
      wait_for(2, e + 10);
      check("interval", n >= e - 4 && n <= e + 4, 1'b1);
      repeat (30) @(negedge mclk);
      check("auto standby", in_standby, 1'b1);
      check("no answer", dones == d, 1'b1);
    end
  endtask

  // main sequence: corner cases first, then the code table and random codes
  initial begin
    void'($urandom(32'hF2E3));
    repeat (5) @(negedge mclk);
    check("reset", {in_standby, spin_down_req, spin_up_req, timer_enabled, resp.done}, 5'h00);
    reset <= 1'b0;
    send(8'hE2, 8'h01);
    wait_for(0, 100);
    check("spun down first", n > 2, 1'b1);
    check("answer", {resp.status, resp.error}, 16'h5000);
    repeat (2) @(negedge mclk);
    check("standby", {in_standby, spin_down_req, standby_z}, 3'b110);
    send(8'h96, 8'h02);
    wait_for(0, 100);
    check("skip spin down", n <= 2, 1'b1);
    send(8'hE2, 8'hFE);
    wait_for(0, 10);
    check("abort", {resp.status, resp.error}, 16'h5104);
    check("kept enable", timer_enabled, 1'b1);
    // an access at 60 of 100 cycles must push expiry a full interval out
    wake();
    repeat (60) @(negedge mclk);
    host_access <= 1'b1;
    @(negedge mclk);
    host_access <= 1'b0;
    // ten frozen cycles must not count, so the window below stays the same
    ce <= 1'b0;
    repeat (10) @(negedge mclk);
    ce <= 1'b1;
    wait_for(2, 200);
    check("reload", n >= 96 && n <= 104, 1'b1);
    epc_enable <= 1'b1;
    send(8'hE2, 8'h00);
    wait_for(0, 100);
    repeat (2) @(negedge mclk);
    check("deep standby", standby_z, 1'b1);
    epc_enable <= 1'b0;
    foreach (codes[i]) timed(codes[i]);
    for (int i = 0; i < 6; i++) begin
      lag <= 8'(1 + $urandom % 8);
      timed(8'(1 + $urandom % 20));
    end
    report_and_stop();
  end
endmodule
`default_nettype wire
